// file: reset_wake_strap_control.sv
// Reset, wake-up and power-on strap control of an Ethernet controller.
// Assumes i_resetn comes from the internal power-on generator, and that
// pins and the host write cycle arrive from outside the clock domain.
`timescale 1ns/10ps
`include "rws_consts.svh"

// Function
// - Pin reset held low returns all logic and registers to reset.
// - Undriven pin reads high; only the power-on reset then initialises.
// - When enabled, a wake event asserts the wake indicator output.
// - Software picks wake indicator polarity and push-pull or open-drain.
// - Wake event and indicator never end the reduced-power state alone.
// - Power-saving state ends only on chip select with write strobe low; the code also ends it on internal reset.
// - Any write to any address while sleeping wakes, whatever the data.
// - Crossover strap high enables auto crossover; low or open disables.
// - Rate strap is latched when reset ends and sets link defaults.
// - Strap 0: 10 Mbps half, no autoneg; 1: 100 Mbps half, autoneg.
module reset_wake_strap_control
    import rws_pkg::*;
(
    input  wire logic        i_clock,
    input  wire logic        i_resetn,
    input  wire logic        i_hw_reset_in_n,
    input  wire logic        i_chip_sel_n,
    input  wire logic        i_write_strobe_n,
    input  wire logic        i_crossover_auto_strap,
    input  wire logic        i_speed_strap,
    input  wire logic        i_wake_event,
    input  wire logic [7:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [31:0] o_rdata,
    output logic             o_irq,
    output logic             o_wake_indicator_out,
    output logic             o_wake_indicator_oe_n,
    output logic             o_power_save,
    output logic             o_speed_100,
    output logic             o_full_duplex,
    output logic             o_autoneg_en,
    output logic             o_crossover_auto_en,
    output logic             o_logic_reset
);

    // Synchronised pins
    logic       hw_rst_sync;
    logic       xover_sync;
    logic       speed_sync;
    logic       wake_sync;

    // Internal reset stretch
    logic [3:0] rst_cnt_q;
    logic [3:0] rst_cnt_d;
    logic       rst_active;
    logic       rst_active_q;
    logic       rst_release;

    // Registers
    logic [`RWS_CTRL_W-1:0] ctrl_q;
    logic [`RWS_CTRL_W-1:0] ctrl_d;
    logic [`RWS_INT_W-1:0]  int_sts_q;
    logic [`RWS_INT_W-1:0]  int_sts_d;
    logic [`RWS_INT_W-1:0]  int_msk_q;
    logic [`RWS_INT_W-1:0]  int_msk_d;
    logic [31:0]            rdata_q;
    logic [31:0]            rdata_d;
    logic                   ready_q;
    logic                   ready_d;
    pstate_e                state_q;
    pstate_e                state_d;

    // Wake indicator and strap outputs
    logic       wake_act_q;
    logic       wake_act_d;
    logic       wake_level;
    logic       wake_out_q;
    logic       wake_oe_n_q;
    logic       irq_q;
    logic       speed_q;
    logic       aneg_q;
    logic       xover_q;

    // Asynchronous wake catch
    logic       wake_cycle;
    logic       wake_clr_n;
    logic       wake_async_q;
    logic       sleeping_q;

    // Pin reset, straps and the caught wake write cross here
    rws_sync3 #(
        .W   (4),
        .RST (4'h1)
    ) u_sync (
        .i_clock  (i_clock),
        .i_resetn (i_resetn),
        .i_async  ({wake_async_q, i_speed_strap, i_crossover_auto_strap,
                    i_hw_reset_in_n}),
        .o_level  ({wake_sync, speed_sync, xover_sync, hw_rst_sync})
    );

    // Internal reset: stretched after power-on, restarted by the pin
    assign rst_active  = (rst_cnt_q != `RWS_RST_HOLD_CYC);
    assign rst_cnt_d   = !hw_rst_sync ? 4'h0 :
                         rst_active   ? rst_cnt_q + 4'h1 : rst_cnt_q;
    assign rst_release = rst_active_q && !rst_active;

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_cnt_q    <= 4'h0;
            rst_active_q <= 1'b1;
        end else begin
            rst_cnt_q    <= rst_cnt_d;
            rst_active_q <= rst_active;
        end
    end

    // Host write cycle caught without the clock, cleared once awake
    assign wake_cycle = ~(i_chip_sel_n | i_write_strobe_n);
    assign wake_clr_n = i_resetn & sleeping_q;

    always_ff @(posedge wake_cycle or negedge wake_clr_n) begin
        if (!wake_clr_n) begin
            wake_async_q <= 1'b0;
        end else begin
            wake_async_q <= 1'b1;
        end
    end

    // Register decode
    wire wr_ok      = i_wr && ready_q && !rst_active;
    wire wr_ctrl    = wr_ok && (i_addr == `RWS_CTRL_OFS);
    wire wr_int_sts = wr_ok && (i_addr == `RWS_INT_STS_OFS);
    wire wr_int_msk = wr_ok && (i_addr == `RWS_INT_MSK_OFS);
    wire sleep_req  = wr_ctrl && i_wdata[`RWS_CTRL_SLEEP];
    wire woke       = (state_q == PS_WAKING);
    wire wake_ev    = i_wake_event && !rst_active;

    // Power state: only the synchronised write cycle or the internal reset ends sleep
    always_comb begin
        state_d = state_q;
        case (state_q)
            PS_AWAKE: begin
                if (sleep_req) begin
                    state_d = PS_SLEEP;
                end
            end
            PS_SLEEP: begin
                if (wake_sync) begin
                    state_d = PS_WAKING;
                end
            end
            PS_WAKING: begin
                state_d = PS_AWAKE;
            end
            default: begin
                state_d = PS_AWAKE;
            end
        endcase
        if (rst_active) begin
            state_d = PS_AWAKE;
        end
    end

    // Host must read again after reset and on each power state change
    always_comb begin
        ready_d = ready_q;
        if (i_rd) begin
            ready_d = 1'b1;
        end
        if (rst_active || sleep_req || woke) begin
            ready_d = 1'b0;
        end
    end

    // Control register; sleep bit reads back as the live state
    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_ctrl) begin
            ctrl_d = i_wdata[`RWS_CTRL_W-1:0];
        end
        ctrl_d[`RWS_CTRL_SLEEP] = 1'b0;
        if (rst_active) begin
            ctrl_d = `RWS_CTRL_RST;
        end
    end

    // Sticky interrupt status, write one to clear; a new event wins
    wire [`RWS_INT_W-1:0] int_set = {woke, wake_ev};
    always_comb begin
        int_sts_d = int_sts_q;
        if (wr_int_sts) begin
            int_sts_d = int_sts_q & ~i_wdata[`RWS_INT_W-1:0];
        end
        int_sts_d = int_sts_d | int_set;
        int_msk_d = wr_int_msk ? i_wdata[`RWS_INT_W-1:0] : int_msk_q;
        if (rst_active) begin
            int_sts_d = `RWS_INT_RST;
            int_msk_d = `RWS_INT_RST;
        end
    end

    // Wake indicator holds until software disables it or reset
    always_comb begin
        wake_act_d = wake_act_q;
        if (wake_ev && ctrl_q[`RWS_CTRL_WAKE_EN]) begin
            wake_act_d = 1'b1;
        end else if (!ctrl_q[`RWS_CTRL_WAKE_EN]) begin
            wake_act_d = 1'b0;
        end
        if (rst_active) begin
            wake_act_d = 1'b0;
        end
    end

    // Pin level for the chosen polarity; open-drain only pulls low
    assign wake_level = wake_act_q ~^ ctrl_q[`RWS_CTRL_POL_HIGH];

    // Read mux; unmapped addresses read zero
    wire [31:0] stat_word  = {29'h0, wake_act_q, ready_q,
                              (state_q != PS_AWAKE)};
    wire [31:0] strap_word = {28'h0, xover_q, aneg_q, 1'b0, speed_q};
    always_comb begin
        case (i_addr)
            `RWS_CTRL_OFS: begin
                rdata_d = {28'h0, (state_q == PS_SLEEP),
                           ctrl_q[`RWS_CTRL_SLEEP-1:0]};
            end
            `RWS_STAT_OFS: begin
                rdata_d = stat_word;
            end
            `RWS_INT_STS_OFS: begin
                rdata_d = {30'h0, int_sts_q};
            end
            `RWS_INT_MSK_OFS: begin
                rdata_d = {30'h0, int_msk_q};
            end
            `RWS_STRAP_OFS: begin
                rdata_d = strap_word;
            end
            `RWS_BYTE_CHECK_OFS: begin
                rdata_d = `RWS_BYTE_CHECK_VAL;
            end
            default: begin
                rdata_d = 32'h0;
            end
        endcase
        if (!i_rd) begin
            rdata_d = 32'h0;
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            state_q    <= PS_AWAKE;
            sleeping_q <= 1'b0;
            ready_q    <= 1'b0;
            ctrl_q     <= `RWS_CTRL_RST;
            int_sts_q  <= `RWS_INT_RST;
            int_msk_q  <= `RWS_INT_RST;
            wake_act_q <= 1'b0;
            rdata_q    <= 32'h0;
        end else begin
            state_q    <= state_d;
            sleeping_q <= (state_d == PS_SLEEP);
            ready_q    <= ready_d;
            ctrl_q     <= ctrl_d;
            int_sts_q  <= int_sts_d;
            int_msk_q  <= int_msk_d;
            wake_act_q <= wake_act_d;
            rdata_q    <= rdata_d;
        end
    end

    // Pin and strap output flops
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            wake_out_q  <= 1'b0;
            wake_oe_n_q <= 1'b1;
            irq_q       <= 1'b0;
            speed_q     <= 1'b0;
            aneg_q      <= 1'b0;
            xover_q     <= 1'b0;
        end else begin
            wake_out_q  <= ctrl_q[`RWS_CTRL_OPEN_DRN] ? 1'b0 : wake_level;
            wake_oe_n_q <= ctrl_q[`RWS_CTRL_OPEN_DRN] ? wake_level : 1'b0;
            irq_q       <= |(int_sts_d & int_msk_d);
            xover_q     <= xover_sync;
            if (rst_release) begin
                speed_q <= speed_sync;
                aneg_q  <= speed_sync;
            end
        end
    end

    assign o_rdata               = rdata_q;
    assign o_irq                 = irq_q;
    assign o_wake_indicator_out  = wake_out_q;
    assign o_wake_indicator_oe_n = wake_oe_n_q;
    assign o_power_save          = sleeping_q;
    assign o_speed_100           = speed_q;
    assign o_full_duplex         = 1'b0;
    assign o_autoneg_en          = aneg_q;
    assign o_crossover_auto_en   = xover_q;
    assign o_logic_reset         = rst_active_q;

    // Checks
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_resetn);

    sequence s_sleeping;
        state_q == PS_SLEEP && !wake_sync;
    endsequence

    sequence s_wake_exit;
        state_q == PS_WAKING ##1 state_q == PS_AWAKE && !ready_q;
    endsequence

    a_pin_reset_clears: assert property (
        !hw_rst_sync |=> ##1 (ctrl_q == `RWS_CTRL_RST && state_q == PS_AWAKE
                              && int_msk_q == `RWS_INT_RST && o_logic_reset))
        else $error("pin reset did not clear logic");

    a_por_hold_len: assert property (
        $fell(rst_active) |-> $past(rst_cnt_q) == `RWS_RST_HOLD_CYC - 4'h1)
        else $error("internal reset stretch has wrong length");

    a_write_before_read: assert property (
        (i_wr && !ready_q && i_addr == `RWS_INT_MSK_OFS)
            |=> int_msk_q == $past(int_msk_q))
        else $error("write took effect before first read");

    a_wake_ind_set: assert property (
        (wake_ev && ctrl_q[`RWS_CTRL_WAKE_EN] && !rst_active)
            |=> wake_act_q ##1 int_sts_q[`RWS_INT_WAKE_EV])
        else $error("wake event did not raise indicator");

    a_wake_pin_mode: assert property (
        i_resetn |=> ($past(ctrl_q[`RWS_CTRL_OPEN_DRN])
             ? (!o_wake_indicator_out && o_wake_indicator_oe_n == $past(wake_level))
             : (!o_wake_indicator_oe_n && o_wake_indicator_out == $past(wake_level))))
        else $error("wake indicator pin mode wrong");

    a_sleep_holds: assert property (
        (s_sleeping and !rst_active) |=> state_q == PS_SLEEP)
        else $error("left sleep without a host write");

    a_write_wakes: assert property (
        (state_q == PS_SLEEP && wake_sync && !rst_active) |=> s_wake_exit)
        else $error("host write did not wake device");

    a_async_catch: assert property (
        (sleeping_q && wake_async_q && !rst_active) |-> ##[1:4] wake_sync)
        else $error("caught wake write not synchronised");

    a_strap_xover: assert property (
        ##1 o_crossover_auto_en == $past(xover_sync))
        else $error("crossover enable does not follow strap");

    a_strap_latch: assert property (
        rst_release |=> (o_speed_100 == $past(speed_sync)
                         && o_autoneg_en == o_speed_100 && !o_full_duplex)
                        ##1 $stable(o_speed_100))
        else $error("rate strap not latched at reset release");

endmodule : reset_wake_strap_control

// file: rws_consts.svh
// Offsets, field positions, reset values and timing counts of the
// reset, wake and strap control block.
// Assumes inclusion by its bare name from every file that needs it.
`ifndef RWS_CONSTS_SVH
`define RWS_CONSTS_SVH

// Register byte offsets
`define RWS_CTRL_OFS       8'h00
`define RWS_STAT_OFS       8'h04
`define RWS_INT_STS_OFS    8'h08
`define RWS_INT_MSK_OFS    8'h0C
`define RWS_STRAP_OFS      8'h10
`define RWS_BYTE_CHECK_OFS 8'h14

// Control register fields
`define RWS_CTRL_WAKE_EN   0
`define RWS_CTRL_POL_HIGH  1
`define RWS_CTRL_OPEN_DRN  2
`define RWS_CTRL_SLEEP     3
`define RWS_CTRL_W         4
`define RWS_CTRL_RST       4'h0

// Status register fields
`define RWS_STAT_PSAVE     0
`define RWS_STAT_READY     1
`define RWS_STAT_WAKE_ACT  2

// Interrupt status and mask fields
`define RWS_INT_WAKE_EV    0
`define RWS_INT_WOKE       1
`define RWS_INT_W          2
`define RWS_INT_RST        2'h0

// Strap register fields
`define RWS_STRAP_SPEED    0
`define RWS_STRAP_DUPLEX   1
`define RWS_STRAP_ANEG     2
`define RWS_STRAP_XOVER    3

// Internal reset stretch after power-on or pin reset, in clock cycles
`define RWS_RST_HOLD_CYC   4'h8

// Read value of the byte-order check register; arbitrary pattern
`define RWS_BYTE_CHECK_VAL 32'hA5C3_0F96

`endif

// file: rws_pkg.sv
// Types shared by the reset, wake and strap control block.
// Assumes nothing of its surroundings.
package rws_pkg;

    // Gray along AWAKE -> SLEEP -> WAKING; WAKING -> AWAKE flips both bits
    typedef enum logic [1:0] {
        PS_AWAKE  = 2'b00,
        PS_SLEEP  = 2'b01,
        PS_WAKING = 2'b11
    } pstate_e;

endpackage : rws_pkg

// file: rws_sync3.sv
// Three-stage synchroniser for pins from outside the clock domain.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/10ps
module rws_sync3 #(
    parameter int          W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         i_clock,
    input  wire logic         i_resetn,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_level
);

    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] level_q;
    logic [W-1:0] level_d;

    // A change counts only once stages two and three agree
    assign level_d = (s2_q & s3_q) | (level_q & (s2_q | s3_q));

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            s1_q    <= RST;
            s2_q    <= RST;
            s3_q    <= RST;
            level_q <= RST;
        end else begin
            s1_q    <= i_async;
            s2_q    <= s1_q;
            s3_q    <= s2_q;
            level_q <= level_d;
        end
    end

    assign o_level = level_q;

endmodule : rws_sync3

// file: testbench.sv
// Self-checking bench of the reset, wake and strap control block.
// Assumes the host wake cycle comes from wake_host_model.
`timescale 1ns/10ps
`include "rws_consts.svh"
module testbench;
    logic        i_clock, i_resetn, i_hw_reset_in_n, i_crossover_auto_strap;
    logic        i_speed_strap, i_wake_event, i_wr, i_rd, wake_go;
    logic [7:0]  i_addr;
    logic [31:0] i_wdata, o_rdata, rd_q;
    logic        o_irq, o_wake_indicator_out, o_wake_indicator_oe_n, o_power_save;
    logic        o_speed_100, o_full_duplex, o_autoneg_en, o_crossover_auto_en;
    logic        o_logic_reset, chip_sel_n, write_strobe_n, sp, xo, pol, od;
    int          err_total, tests_run, cyc, seed;

    reset_wake_strap_control reset_wake_strap_control_i (.*, .i_chip_sel_n(chip_sel_n),
        .i_write_strobe_n(write_strobe_n));
    wake_host_model wake_host_model_i (.i_start(wake_go), .o_chip_sel_n(chip_sel_n),
        .o_write_strobe_n(write_strobe_n), .o_pin_addr());

    initial begin
        i_clock = 1'b0;
        forever #50 i_clock = ~i_clock;
    end

    task automatic tally_and_finish();
        $display("errors %0d of %0d checks", err_total, tests_run);
        if (err_total == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : tally_and_finish

    // Ceiling well above the few hundred cycles the sequence needs
    always @(posedge i_clock) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            tally_and_finish();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("unexpected %s: expected %h seen %h", what, exp, got);
            err_total++;
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clock);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_clock);
        i_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge i_clock);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_clock);
        i_rd   <= 1'b0;
        #1 rd_q = o_rdata;
    endtask : rd

    task automatic wait_ready();
        for (int n = 0; n < 40 && o_logic_reset !== 1'b0; n++)
            @(posedge i_clock);
        chk("logic reset", 0, o_logic_reset);
    endtask : wait_ready

    function automatic logic [31:0] ctrl(input logic en, p, o, s);
        return (32'(en) << `RWS_CTRL_WAKE_EN) | (32'(p) << `RWS_CTRL_POL_HIGH)
             | (32'(o) << `RWS_CTRL_OPEN_DRN) | (32'(s) << `RWS_CTRL_SLEEP);
    endfunction : ctrl

    // Both strap settings are half duplex; autoneg follows the speed
    function automatic logic [31:0] strap_word(input logic s, x);
        return (32'(s) << `RWS_STRAP_SPEED) | (32'(s) << `RWS_STRAP_ANEG)
             | (32'(x) << `RWS_STRAP_XOVER);
    endfunction : strap_word

    task automatic check_straps();
        i_speed_strap          <= ~sp;
        i_crossover_auto_strap <= ~xo;
        repeat (6) @(posedge i_clock);
        chk("speed 100", 32'(sp), 32'(o_speed_100));
        chk("autoneg", 32'(sp), 32'(o_autoneg_en));
        chk("full duplex", 0, 32'(o_full_duplex));
        chk("crossover flip", 32'(!xo), 32'(o_crossover_auto_en));
        rd(`RWS_STRAP_OFS);
        chk("strap reg", strap_word(sp, !xo), rd_q);
        i_crossover_auto_strap <= xo;
        repeat (6) @(posedge i_clock);
        chk("crossover", 32'(xo), 32'(o_crossover_auto_en));
    endtask : check_straps

    initial begin
        seed = 32'hC01A;
        err_total = 0;
        tests_run = 0;
        {i_resetn, i_wr, i_rd, i_wake_event, wake_go} = '0;
        i_hw_reset_in_n = 1'b1;
        i_addr  = 8'h00;
        i_wdata = 32'h0;
        sp = 1'($random(seed));
        xo = 1'($random(seed));
        i_speed_strap          = sp;
        i_crossover_auto_strap = xo;
        repeat (16) @(posedge i_clock);
        i_resetn <= 1'b1;
        wait_ready();
        wr(`RWS_INT_MSK_OFS, 32'h3);
        rd(`RWS_INT_MSK_OFS);
        chk("mask before read", 0, rd_q);
        check_straps();
        rd(`RWS_BYTE_CHECK_OFS);
        chk("byte check", `RWS_BYTE_CHECK_VAL, rd_q);
        wr(`RWS_INT_MSK_OFS, 32'h3);
        wr(8'h3C, $random(seed));
        rd(8'h3C);
        chk("unmapped", 0, rd_q);
        rd(`RWS_INT_MSK_OFS);
        chk("mask", 32'h3, rd_q);
        for (int m = 0; m < 4; m++) begin
            {od, pol} = 2'(m);
            wr(`RWS_CTRL_OFS, ctrl(1'b1, pol, od, 1'b0));
            @(posedge i_clock);
            i_wake_event <= 1'b1;
            @(posedge i_clock);
            i_wake_event <= 1'b0;
            repeat (3) @(posedge i_clock);
            chk("wake out", 32'(od ? 1'b0 : pol), 32'(o_wake_indicator_out));
            chk("wake oe_n", 32'(od ? pol : 1'b0), 32'(o_wake_indicator_oe_n));
            chk("irq on", 1, 32'(o_irq));
            wr(`RWS_INT_STS_OFS, 32'h3);
            wr(`RWS_CTRL_OFS, ctrl(1'b0, pol, od, 1'b0));
            repeat (3) @(posedge i_clock);
            chk("irq off", 0, 32'(o_irq));
            chk("idle out", 32'(od ? 1'b0 : !pol), 32'(o_wake_indicator_out));
            chk("idle oe_n", 32'(od ? !pol : 1'b0), 32'(o_wake_indicator_oe_n));
        end
        wr(`RWS_INT_MSK_OFS, 32'h2);
        wr(`RWS_CTRL_OFS, ctrl(1'b1, 1'b1, 1'b0, 1'b1));
        repeat (3) @(posedge i_clock);
        chk("asleep", 1, 32'(o_power_save));
        i_wake_event <= 1'b1;
        @(posedge i_clock);
        i_wake_event <= 1'b0;
        repeat (12) @(posedge i_clock);
        chk("event stays asleep", 1, 32'(o_power_save));
        chk("indicator asleep", 1, 32'(o_wake_indicator_out));
        chk("irq masked", 0, 32'(o_irq));
        wr(`RWS_INT_STS_OFS, 32'h3);
        rd(`RWS_CTRL_OFS);
        chk("ctrl asleep", 32'hB, rd_q);
        wake_go <= 1'b1;
        @(posedge i_clock);
        wake_go <= 1'b0;
        for (int n = 0; n < 20 && o_power_save !== 1'b0; n++)
            @(posedge i_clock);
        chk("woken", 0, 32'(o_power_save));
        repeat (2) @(posedge i_clock);
        chk("woke irq", 1, 32'(o_irq));
        wr(`RWS_INT_MSK_OFS, 32'h0);
        rd(`RWS_INT_MSK_OFS);
        chk("mask after wake", 32'h2, rd_q);
        rd(`RWS_INT_STS_OFS);
        chk("woke status", 32'h3, rd_q);
        rd(`RWS_STAT_OFS);
        chk("status word", 32'h6, rd_q);
        for (int s = 0; s < 2; s++) begin
            sp = 1'(s);
            xo = 1'($random(seed));
            i_speed_strap          <= sp;
            i_crossover_auto_strap <= xo;
            i_hw_reset_in_n        <= 1'b0;
            repeat (6) @(posedge i_clock);
            i_hw_reset_in_n        <= 1'b1;
            repeat (4) @(posedge i_clock);
            wait_ready();
            check_straps();
            rd(`RWS_INT_MSK_OFS);
            chk("mask after pin reset", 0, rd_q);
            rd(`RWS_CTRL_OFS);
            chk("ctrl after pin reset", 0, rd_q);
        end
        tally_and_finish();
    end
endmodule : testbench

// file: wake_host_model.sv
// Host side of the wake-up path: one chip-select and write strobe cycle
// aimed at the byte-order check register, timed by fixed delays after i_start.
// Assumes the bench pulses i_start; both pins idle high between cycles.
`timescale 1ns/10ps
`include "rws_consts.svh"
module wake_host_model (
    input  wire logic       i_start,
    output logic            o_chip_sel_n,
    output logic            o_write_strobe_n,
    output logic [7:0]      o_pin_addr
);
    // Odd delays so the cycle never lines up with a clock edge
    initial begin
        o_chip_sel_n     = 1'b1;
        o_write_strobe_n = 1'b1;
        o_pin_addr       = 8'hFF;
        forever begin
            @(posedge i_start);
            #37;
            o_pin_addr       = `RWS_BYTE_CHECK_OFS;
            o_chip_sel_n     = 1'b0;
            #23;
            o_write_strobe_n = 1'b0;
            #180;
            o_write_strobe_n = 1'b1;
            #15;
            o_chip_sel_n     = 1'b1;
            // Released bus must not keep showing the last address
            o_pin_addr       = ~`RWS_BYTE_CHECK_OFS;
        end
    end
endmodule : wake_host_model
